// ### dts_pkg.sv
// Package for the DMA transfer sequencer: constants, states and carriers
package dts_pkg;
    localparam int DTS_CHANNELS = 4;
    // Command setting bit positions
    localparam int DTS_CMD_MEM2MEM = 0;
    localparam int DTS_CMD_ADDR_HOLD = 1;
    localparam int DTS_CMD_DISABLE = 2;
    localparam int DTS_CMD_COMPRESSED = 3;
    localparam int DTS_CMD_ROTATING = 4;
    // Mode setting field positions
    localparam int DTS_MODE_TYPE_LO = 2;
    localparam int DTS_MODE_AUTO = 4;
    localparam int DTS_MODE_DECR = 5;
    // Transfer type codes
    localparam logic [1:0] DTS_TYPE_VERIFY = 2'h0;
    localparam logic [1:0] DTS_TYPE_WRITE = 2'h1;
    localparam logic [1:0] DTS_TYPE_READ = 2'h2;
    // Reset values and count wrap value
    localparam logic [3:0] DTS_MASK_RESET = 4'hf;
    localparam logic [15:0] DTS_COUNT_WRAP = 16'hffff;
    localparam logic [1:0] DTS_LAST_RESET = 2'h3;

    // Working states of a service
    typedef enum logic [3:0] {
        DTS_IDLE = 4'h0,
        DTS_WAIT_GRANT = 4'h1,
        DTS_UPPER = 4'h2,
        DTS_CHANGE = 4'h3,
        DTS_EXTEND = 4'h4,
        DTS_RDWR = 4'h5,
        DTS_M_UPPER = 4'h6,
        DTS_M_READ = 4'h7,
        DTS_M_WUPPER = 4'h8,
        DTS_M_WRITE = 4'h9,
        DTS_RELEASE = 4'ha
    } dts_state_type;

    // Host programming request for one channel word
    typedef struct packed {
        logic load;
        logic [1:0] chan;
        logic is_count;
        logic [15:0] value;
    } dts_prog_type;

    // Memory and I/O strobes, all active low
    typedef struct packed {
        logic mem_read_n;
        logic mem_write_n;
        logic io_read_n;
        logic io_write_n;
    } dts_strobe_type;
endpackage

// ### dts_sequencer.sv
// Transfer sequencer of a four-channel byte DMA controller
`timescale 1ns/10ps
// Operation
// - Write type asserts memory write with I/O read.
// - Read type asserts memory read with I/O write.
// - Verify sequences addresses but keeps strobes idle, ignores ready.
// - Auto-reload copies base address and count into current after end.
// - Auto-reload channel is not masked at end, serves again on request.
// - Host write loads base and current together; base stays unchanged.
// - Command bit 0 pairs channel 0 source with channel 1 destination.
// - Memory move reads via channel 0 into holding, writes via channel 1.
// - Channel 1 wrap gives terminal count, ends, flags, masks unless reload.
// - Channel 0 wrap in memory move only reloads channel 0 if selected.
// - Command bit 1 holds channel 0 source address constant.
// - External end in memory move acts after write; reloads channel 1 only.
// - Memory move drives address enable with no acknowledge active.
// - Fixed priority 0 over 1 over 2 over 3; no preemption.
// - Rotating priority makes served channel lowest on each release.
// - Priority is evaluated each time the bus grant returns.
// - Compressed timing drops extension state; upper state still inserted.
// - Compressed timing drives end-of-process in the change state, except in memory move.
// - Upper address on data lines in upper state, strobed, lower direct.
// - Upper state only when upper byte changes in single-channel multi transfers; memory move inserts both upper states every byte.
// - Host programming accepted only with grant low for one edge.
// - Command bit 2 disables the controller; no service starts.
// - End-of-process comes from terminal count or external pin.
module dts_sequencer
    import dts_pkg::*;
#(
    parameter int CHANNELS = DTS_CHANNELS
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [7:0] COMMAND,
    input wire logic [5:0] MODE [CHANNELS],
    input wire logic [3:0] MASK_SET,
    input wire logic [3:0] MASK_CLEAR,
    input wire logic [3:0] SOFT_REQUEST,
    input wire dts_prog_type PROG,
    input wire logic [3:0] CHANNEL_REQUEST,
    input wire logic BUS_GRANT,
    input wire logic READY,
    input wire logic END_OF_PROCESS_IN_N,
    input wire logic [7:0] DATA_IN,
    output logic BUS_REQUEST,
    output logic [3:0] CHANNEL_ACKNOWLEDGE,
    output logic ADDRESS_ENABLE,
    output logic ADDRESS_STROBE,
    output logic [7:0] ADDRESS_LOW,
    output logic [7:0] DATA_OUT,
    output logic DATA_OUT_EN_N,
    output dts_strobe_type STROBES_N,
    output logic END_OF_PROCESS_N,
    output logic TERMINAL_COUNT,
    output logic [3:0] TC_STATUS,
    output logic [3:0] MASK,
    output logic PROG_ACCEPTED,
    output logic [7:0] HOLDING
);
    // Pin synchronisers: first stage read only by the second
    logic [3:0] req_s1_reg, req_s2_reg;
    logic grant_s1_reg, grant_s2_reg, ready_s1_reg, ready_s2_reg;
    logic eop_s1_reg, eop_s2_reg;
    always_ff @(posedge CLOCK) begin
        req_s1_reg <= CHANNEL_REQUEST;
        req_s2_reg <= req_s1_reg;
        grant_s1_reg <= BUS_GRANT;
        grant_s2_reg <= grant_s1_reg;
        ready_s1_reg <= READY;
        ready_s2_reg <= ready_s1_reg;
        eop_s1_reg <= END_OF_PROCESS_IN_N;
        eop_s2_reg <= eop_s1_reg;
    end
    wire logic ext_eop = ~eop_s2_reg;

    logic [15:0] base_addr_reg [CHANNELS];
    logic [15:0] base_cnt_reg [CHANNELS];
    logic [15:0] cur_addr_reg [CHANNELS];
    logic [15:0] cur_cnt_reg [CHANNELS];
    dts_state_type state_reg, state_next;
    logic [1:0] chan_reg, last_reg;
    logic [3:0] mask_reg, soft_reg, tc_reg;
    logic grant_low_seen_reg, first_reg, eop_pend_reg;

    wire logic m2m = COMMAND[DTS_CMD_MEM2MEM];
    wire logic compressed = COMMAND[DTS_CMD_COMPRESSED];
    wire logic [3:0] pending = (req_s2_reg & ~mask_reg) | soft_reg;
    wire logic [1:0] xtype = MODE[chan_reg][DTS_MODE_TYPE_LO +: 2];
    wire logic is_verify = (xtype == DTS_TYPE_VERIFY) && !m2m;

    // Priority pick; rotation starts after the last served channel
    function automatic logic [1:0] pick(input logic [3:0] p,
                                        input logic [1:0] start);
        logic [1:0] c;
        pick = start;
        for (int i = 3; i >= 0; i--) begin
            c = 2'(start + 2'(i));
            if (p[c]) begin
                pick = c;
            end
        end
    endfunction
    // Next address stepping up or down by one
    function automatic logic [15:0] step(input logic [15:0] a,
                                         input logic dec);
        step = dec ? 16'(a - 16'h1) : 16'(a + 16'h1);
    endfunction

    // Host programming window: grant low and one edge since it fell
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            grant_low_seen_reg <= 1'b0;
        end else begin
            grant_low_seen_reg <= !grant_s2_reg && state_reg == DTS_IDLE;
        end
    end
    wire logic prog_ok = grant_low_seen_reg && !grant_s2_reg;

    // Transfer service state machine
    wire logic [1:0] xch = (state_reg == DTS_M_WRITE ||
                            state_reg == DTS_M_WUPPER) ? 2'h1 : chan_reg;
    wire logic [15:0] nxt_addr = step(cur_addr_reg[xch],
                                      MODE[xch][DTS_MODE_DECR]);
    wire logic upper_chg = nxt_addr[15:8] != cur_addr_reg[xch][15:8];
    wire logic wrap = cur_cnt_reg[xch] == 16'h0;
    wire logic xfer_done = (state_reg == DTS_RDWR) &&
                           (is_verify || ready_s2_reg);
    wire logic m_done = (state_reg == DTS_M_WRITE) && ready_s2_reg;
    wire logic end_svc = (xfer_done && (wrap || ext_eop)) ||
                         (m_done && (wrap || eop_pend_reg || ext_eop));
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DTS_IDLE: begin
                if (!COMMAND[DTS_CMD_DISABLE] &&
                    (m2m ? pending[0] : |pending)) begin
                    state_next = DTS_WAIT_GRANT;
                end
            end
            DTS_WAIT_GRANT: begin
                if (grant_s2_reg) begin
                    state_next = m2m ? DTS_M_UPPER : DTS_UPPER;
                end
            end
            DTS_UPPER: state_next = DTS_CHANGE;
            DTS_CHANGE: begin
                state_next = compressed ? DTS_RDWR : DTS_EXTEND;
            end
            DTS_EXTEND: state_next = DTS_RDWR;
            DTS_RDWR: begin
                if (end_svc) begin
                    state_next = DTS_RELEASE;
                end else if (xfer_done) begin
                    // Upper state only on carry or borrow
                    state_next = upper_chg ? DTS_UPPER : DTS_CHANGE;
                end
            end
            DTS_M_UPPER: state_next = DTS_M_READ;
            DTS_M_READ: begin
                if (ready_s2_reg) begin
                    state_next = DTS_M_WUPPER;
                end
            end
            DTS_M_WUPPER: state_next = DTS_M_WRITE;
            DTS_M_WRITE: begin
                if (end_svc) begin
                    state_next = DTS_RELEASE;
                end else if (m_done) begin
                    state_next = DTS_M_UPPER;
                end
            end
            DTS_RELEASE: begin
                if (!grant_s2_reg) begin
                    state_next = DTS_IDLE;
                end
            end
            default: state_next = DTS_IDLE;
        endcase
    end
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_reg <= DTS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Channel choice; fixed or rotating, re-evaluated at each grant
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            chan_reg <= 2'h0;
            last_reg <= DTS_LAST_RESET;
        end else begin
            if (state_reg == DTS_WAIT_GRANT && grant_s2_reg) begin
                // Fixed starts at 0, else after last
                chan_reg <= m2m ? 2'h0 : pick(pending,
                    COMMAND[DTS_CMD_ROTATING] ? 2'(last_reg + 2'h1) : 2'h0);
            end
            if (state_reg == DTS_RELEASE && !grant_s2_reg) begin
                last_reg <= chan_reg;
            end
        end
    end

    // Latched external end during a memory move, acted on after the write
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || state_reg == DTS_IDLE) begin
            eop_pend_reg <= 1'b0;
        end else if (ext_eop && state_reg >= DTS_M_UPPER) begin
            eop_pend_reg <= 1'b1;
        end
    end

    // Address and count words per channel
    always_ff @(posedge CLOCK) begin
        if (PROG.load && prog_ok) begin
            if (PROG.is_count) begin
                base_cnt_reg[PROG.chan] <= PROG.value;
                cur_cnt_reg[PROG.chan] <= PROG.value;
            end else begin
                base_addr_reg[PROG.chan] <= PROG.value;
                cur_addr_reg[PROG.chan] <= PROG.value;
            end
        end else if (xfer_done || m_done) begin
            cur_addr_reg[xch] <= nxt_addr;
            cur_cnt_reg[xch] <= 16'(cur_cnt_reg[xch] - 16'h1);
            if (end_svc && MODE[xch][DTS_MODE_AUTO]) begin
                cur_addr_reg[xch] <= base_addr_reg[xch];
                cur_cnt_reg[xch] <= base_cnt_reg[xch];
            end
        end else if (state_reg == DTS_M_READ && ready_s2_reg) begin
            // Source step, address may be held
            if (!COMMAND[DTS_CMD_ADDR_HOLD]) begin
                cur_addr_reg[0] <= step(cur_addr_reg[0],
                                        MODE[0][DTS_MODE_DECR]);
            end
            cur_cnt_reg[0] <= 16'(cur_cnt_reg[0] - 16'h1);
            if (cur_cnt_reg[0] == 16'h0 && MODE[0][DTS_MODE_AUTO]) begin
                cur_addr_reg[0] <= base_addr_reg[0];
                cur_cnt_reg[0] <= base_cnt_reg[0];
            end
        end
    end

    // Mask, software requests and terminal count flags
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            mask_reg <= DTS_MASK_RESET;
            soft_reg <= 4'h0;
            tc_reg <= 4'h0;
        end else begin
            mask_reg <= (mask_reg & ~MASK_CLEAR) | MASK_SET;
            soft_reg <= soft_reg | SOFT_REQUEST;
            tc_reg <= tc_reg;
            if (end_svc) begin
                // Flag set; mask only without reload
                tc_reg[xch] <= 1'b1;
                soft_reg[xch] <= 1'b0;
                if (!MODE[xch][DTS_MODE_AUTO]) begin
                    mask_reg[xch] <= 1'b1;
                end
                if (m2m) begin
                    soft_reg[0] <= 1'b0;
                end
            end
        end
    end

    // Capture the source byte one state after the read state: the read
    // strobe is registered, so memory data is only valid in that cycle
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            HOLDING <= 8'h0;
        end else if (state_reg == DTS_M_WUPPER) begin
            HOLDING <= DATA_IN;
        end
    end

    // Registered pin outputs
    wire logic upper_st = state_reg == DTS_UPPER ||
                          state_reg == DTS_M_UPPER ||
                          state_reg == DTS_M_WUPPER;
    wire logic active = state_reg >= DTS_UPPER &&
                        state_reg <= DTS_M_WRITE;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            BUS_REQUEST <= 1'b0;
            CHANNEL_ACKNOWLEDGE <= 4'h0;
            ADDRESS_ENABLE <= 1'b0;
            ADDRESS_STROBE <= 1'b0;
            ADDRESS_LOW <= 8'h0;
            DATA_OUT <= 8'h0;
            DATA_OUT_EN_N <= 1'b1;
            STROBES_N <= '1;
            END_OF_PROCESS_N <= 1'b1;
            TERMINAL_COUNT <= 1'b0;
            PROG_ACCEPTED <= 1'b0;
        end else begin
            BUS_REQUEST <= state_next != DTS_IDLE &&
                           state_next != DTS_RELEASE;
            ADDRESS_ENABLE <= active;
            CHANNEL_ACKNOWLEDGE <= (active && !m2m) ?
                4'(4'h1 << chan_reg) : 4'h0;
            ADDRESS_STROBE <= upper_st; // Falls leaving state
            ADDRESS_LOW <= active ? cur_addr_reg[xch][7:0] : 8'h0;
            DATA_OUT <= upper_st ? cur_addr_reg[xch][15:8] : HOLDING;
            DATA_OUT_EN_N <= !(upper_st || state_reg == DTS_M_WRITE);
            STROBES_N <= '1;
            if (state_reg == DTS_RDWR && !is_verify) begin
                STROBES_N.mem_write_n <= xtype != DTS_TYPE_WRITE;
                STROBES_N.io_read_n <= xtype != DTS_TYPE_WRITE;
                STROBES_N.mem_read_n <= xtype != DTS_TYPE_READ;
                STROBES_N.io_write_n <= xtype != DTS_TYPE_READ;
            end
            if (state_reg == DTS_M_READ) begin
                STROBES_N.mem_read_n <= 1'b0;
            end
            if (state_reg == DTS_M_WRITE) begin
                STROBES_N.mem_write_n <= 1'b0;
            end
            // Compressed drives end in change state, except memory move (write state)
            END_OF_PROCESS_N <= !((compressed && !m2m &&
                state_reg == DTS_CHANGE && wrap) ||
                (!compressed && state_reg == DTS_RDWR && wrap) ||
                (m2m && state_reg == DTS_M_WRITE && wrap));
            TERMINAL_COUNT <= (xfer_done || m_done) && wrap;
            PROG_ACCEPTED <= PROG.load && prog_ok;
        end
    end
    assign TC_STATUS = tc_reg;
    assign MASK = mask_reg;

    a_disable_blocks: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (state_reg == DTS_IDLE && COMMAND[DTS_CMD_DISABLE])
        |=> state_reg == DTS_IDLE)
        else $error("service started while disabled");
    a_m2m_no_ack: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (m2m && $stable(COMMAND) && ADDRESS_ENABLE)
        |-> CHANNEL_ACKNOWLEDGE == 4'h0)
        else $error("acknowledge active in memory move");
    a_verify_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (state_reg == DTS_RDWR && is_verify) |=> STROBES_N == '1)
        else $error("strobe active during verify");
    a_write_pair: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !STROBES_N.io_read_n |-> !STROBES_N.mem_write_n)
        else $error("I/O read without memory write");
    a_read_pair: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !STROBES_N.io_write_n |-> !STROBES_N.mem_read_n)
        else $error("I/O write without memory read");
    a_prog_window: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        PROG_ACCEPTED |-> $past(!grant_s2_reg, 2))
        else $error("programming taken during grant");
    a_compress_len: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        (state_reg == DTS_CHANGE && compressed) |=> state_reg == DTS_RDWR)
        else $error("extension state not dropped");
    a_base_steady: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        active |=> $stable(base_cnt_reg[1]))
        else $error("base count changed in service");
    a_tc_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        TERMINAL_COUNT |-> tc_reg != 4'h0)
        else $error("terminal count without status flag");
endmodule

// ### dts_partner.sv
// Far-side model: bus grant of the host, memory data and ready
`timescale 1ns/10ps
module dts_partner
    import dts_pkg::*;
(
    input wire logic clock,
    input wire logic bus_request,
    input wire logic mem_read_n,
    input wire logic [7:0] address_low,
    input wire logic slow,
    input wire logic stall,
    output logic bus_grant,
    output logic ready,
    output logic [7:0] data_in
);
    logic [1:0] wait_reg = 2'h0;
    logic [7:0] idle_reg = 8'h00;
    logic tog_reg = 1'b0;
    initial bus_grant = 1'b0;
    // Host hands the bus over after a short delay and takes it back
    // as soon as the request drops, so programming never overlaps it
    always @(posedge clock) begin
        if (!bus_request) begin
            bus_grant <= 1'b0;
            wait_reg <= 2'h0;
        end else if (wait_reg == 2'h2) begin
            bus_grant <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
    // Idle pattern changes every cycle so stale data never looks valid
    always @(posedge clock) begin
        tog_reg <= ~tog_reg;
        idle_reg <= idle_reg + 8'h35;
    end
    // Slow memory drops ready every other cycle; stall never answers
    assign ready = !stall && (!slow || tog_reg);
    assign data_in = !mem_read_n ? (address_low ^ 8'h5a) : idle_reg;
endmodule

// ### tb.sv
// Self-checking testbench for the DMA transfer sequencer
`timescale 1ns/10ps
module tb;
    import dts_pkg::*;
    typedef struct packed {
        logic [3:0] ack;
        logic [7:0] wr;
        logic [7:0] rd;
        logic [7:0] mm;
        logic address_enable;
        logic [1:0] tc;
    } dts_rec_type;
    logic clock;
    logic sys_rst = 1'b1;
    logic [7:0] command = 8'h00;
    logic [5:0] mode [4] = '{default: 6'h00};
    logic [3:0] mask_clear = 4'h0;
    logic [3:0] soft_req = 4'h0;
    logic [3:0] chan_req = 4'h0;
    logic slow = 1'b0;
    logic stall = 1'b0;
    logic ext_eop_n = 1'b1;
    dts_prog_type prog = '0;
    logic bus_request, bus_grant, ready, address_enable, address_strobe, dout_en_n, eop_n, tc;
    logic prog_acc;
    logic [3:0] ack, tc_status, mask;
    logic [7:0] addr_low, dout, holding, data_in;
    dts_strobe_type strobes_n;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] lfsr = 32'h070e1e2b;
    logic [15:0] base_addr;
    dts_rec_type exp_q [$];
    dts_rec_type seen = '0;
    dts_strobe_type prev_s = 4'hf;
    logic prev_req = 1'b0;

    dts_sequencer u_dts_sequencer (
        .CLOCK(clock), .SYS_RST(sys_rst), .COMMAND(command), .MODE(mode),
        .MASK_SET(4'h0), .MASK_CLEAR(mask_clear), .SOFT_REQUEST(soft_req),
        .PROG(prog), .CHANNEL_REQUEST(chan_req), .BUS_GRANT(bus_grant),
        .READY(ready), .END_OF_PROCESS_IN_N(ext_eop_n), .DATA_IN(data_in),
        .BUS_REQUEST(bus_request), .CHANNEL_ACKNOWLEDGE(ack),
        .ADDRESS_ENABLE(address_enable), .ADDRESS_STROBE(address_strobe),
        .ADDRESS_LOW(addr_low), .DATA_OUT(dout), .DATA_OUT_EN_N(dout_en_n),
        .STROBES_N(strobes_n), .END_OF_PROCESS_N(eop_n),
        .TERMINAL_COUNT(tc), .TC_STATUS(tc_status), .MASK(mask),
        .PROG_ACCEPTED(prog_acc), .HOLDING(holding));
    dts_partner u_dts_partner (
        .clock(clock), .bus_request(bus_request),
        .mem_read_n(strobes_n.mem_read_n), .address_low(addr_low),
        .slow(slow), .stall(stall), .bus_grant(bus_grant), .ready(ready),
        .data_in(data_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [15:0] seen_v,
            input logic [15:0] exp_v);
        tests_run++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask

    task automatic summarize();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One record per service, compared when the bus request drops; the
    // last strobe and the terminal count pulse show in the same cycle as that drop
    always @(posedge clock) begin
        dts_rec_type e;
        if (bus_request === 1'b1 || prev_req) begin
            seen.ack = seen.ack | ack;
            seen.address_enable = seen.address_enable | address_enable;
            seen.tc = seen.tc | {tc, !eop_n};
            if (prev_s.mem_write_n && !strobes_n.mem_write_n) begin
                if (!strobes_n.io_read_n) seen.wr = seen.wr + 8'h01;
                else seen.mm = seen.mm + 8'h01;
            end
            if (prev_s.mem_read_n && !strobes_n.mem_read_n
                    && !strobes_n.io_write_n) seen.rd = seen.rd + 8'h01;
        end
        if (bus_request !== 1'b1 && prev_req) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("Error service expected none seen one");
            end else begin
                e = exp_q.pop_front();
                check("ack", 16'(seen.ack), 16'(e.ack));
                check("wr_pairs", 16'(seen.wr), 16'(e.wr));
                check("rd_pairs", 16'(seen.rd), 16'(e.rd));
                check("mem_writes", 16'(seen.mm), 16'(e.mm));
                check("addr_enable", 16'(seen.address_enable), 16'(e.address_enable));
                check("end_signals", 16'(seen.tc), 16'(e.tc));
            end
            seen = '0;
        end
        prev_s = strobes_n;
        prev_req = bus_request;
    end

    // Host load of one word; the accept pulse tells if it was taken
    task automatic prog_word(input int ch, input logic is_cnt,
            input logic [15:0] v, input logic want);
        logic acc;
        acc = 1'b0;
        prog <= '{1'b1, 2'(ch), is_cnt, v};
        @(posedge clock);
        prog <= '0;
        repeat (4) begin
            @(posedge clock);
            acc = acc | prog_acc;
        end
        check("prog_accepted", 16'(acc), 16'(want));
    endtask

    task automatic setup(input int ch, input logic [1:0] typ,
            input logic auto_r, input logic [15:0] cnt);
        lfsr = lfsr_step(lfsr);
        base_addr = lfsr[15:0];
        mode[ch] <= {1'b0, auto_r, typ, 2'h0};
        prog_word(ch, 1'b0, base_addr, 1'b1);
        prog_word(ch, 1'b1, cnt, 1'b1);
        mask_clear <= 4'h1 << ch;
        @(posedge clock);
        mask_clear <= 4'h0;
    endtask

    task automatic note(input int ch, input logic [1:0] typ,
            input logic [15:0] cnt);
        dts_rec_type r;
        r = '0;
        r.ack = 4'h1 << ch;
        r.address_enable = 1'b1;
        r.tc = 2'h3;
        if (typ == DTS_TYPE_WRITE) r.wr = 8'(cnt + 16'h1);
        if (typ == DTS_TYPE_READ) r.rd = 8'(cnt + 16'h1);
        exp_q.push_back(r);
    endtask

    // Request held until acknowledged, as a block-mode device would
    task automatic hw_req(input int ch);
        int n;
        n = 0;
        @(posedge clock);
        chan_req[ch] <= 1'b1;
        while (ack[ch] !== 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        chan_req[ch] <= 1'b0;
    endtask

    task automatic wait_done(input string name);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        check("services_left", 16'(exp_q.size()), 16'h0);
        repeat (6) @(posedge clock);
        $display("Test %s done", name);
    endtask

    // Main sequence
    initial begin
        logic [15:0] cnt;
        logic seen_req;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clock);
        check("mask_reset", 16'(mask), 16'(DTS_MASK_RESET));
        lfsr = lfsr_step(lfsr);
        cnt = {14'h0, lfsr[1:0]};
        slow <= 1'b1;
        setup(2, DTS_TYPE_WRITE, 1'b0, cnt);
        note(2, DTS_TYPE_WRITE, cnt);
        hw_req(2);
        wait_done("write");
        check("mask_end", 16'(mask[2]), 16'h1);
        check("tc_flag", 16'(tc_status[2]), 16'h1);
        slow <= 1'b0;
        command <= 8'h08;
        setup(3, DTS_TYPE_READ, 1'b0, cnt);
        note(3, DTS_TYPE_READ, cnt);
        hw_req(3);
        wait_done("read_compressed");
        // Verify must finish although ready is never given
        command <= 8'h00;
        stall <= 1'b1;
        setup(2, DTS_TYPE_VERIFY, 1'b0, 16'h2);
        note(2, DTS_TYPE_VERIFY, 16'h2);
        hw_req(2);
        wait_done("verify");
        // External end cuts a long verify service short, no count end
        setup(2, DTS_TYPE_VERIFY, 1'b0, 16'h0fff);
        exp_q.push_back('{4'h4, 8'h0, 8'h0, 8'h0, 1'b1, 2'h0});
        hw_req(2);
        ext_eop_n <= 1'b0;
        wait_done("external_end");
        ext_eop_n <= 1'b1;
        check("mask_ext", 16'(mask[2]), 16'h1);
        stall <= 1'b0;
        setup(1, DTS_TYPE_WRITE, 1'b1, 16'h1);
        repeat (2) begin
            note(1, DTS_TYPE_WRITE, 16'h1);
            hw_req(1);
            wait_done("autoreload");
            check("mask_auto", 16'(mask[1]), 16'h0);
        end
        command <= 8'h04;
        setup(0, DTS_TYPE_WRITE, 1'b0, 16'h0);
        chan_req[0] <= 1'b1;
        seen_req = 1'b0;
        repeat (30) begin
            @(posedge clock);
            seen_req = seen_req | bus_request;
        end
        check("disabled_request", 16'(seen_req), 16'h0);
        note(0, DTS_TYPE_WRITE, 16'h0);
        command <= 8'h00;
        hw_req(0);
        wait_done("disable");
        // Two requests at once; a host load mid-service is refused
        setup(2, DTS_TYPE_WRITE, 1'b0, 16'h0);
        setup(3, DTS_TYPE_WRITE, 1'b0, 16'h0);
        note(2, DTS_TYPE_WRITE, 16'h0);
        note(3, DTS_TYPE_WRITE, 16'h0);
        chan_req <= 4'hc;
        hw_req(2);
        prog_word(3, 1'b0, 16'h1234, 1'b0);
        hw_req(3);
        wait_done("fixed_priority");
        command <= 8'h10;
        setup(2, DTS_TYPE_WRITE, 1'b0, 16'h0);
        note(2, DTS_TYPE_WRITE, 16'h0);
        hw_req(2);
        wait_done("rotate_first");
        setup(2, DTS_TYPE_WRITE, 1'b0, 16'h0);
        setup(3, DTS_TYPE_WRITE, 1'b0, 16'h0);
        note(3, DTS_TYPE_WRITE, 16'h0);
        note(2, DTS_TYPE_WRITE, 16'h0);
        chan_req <= 4'hc;
        hw_req(3);
        hw_req(2);
        wait_done("rotating_priority");
        // Memory move of two bytes from channel 0 to channel 1
        command <= 8'h01;
        setup(1, DTS_TYPE_WRITE, 1'b0, 16'h1);
        setup(0, DTS_TYPE_READ, 1'b0, 16'h1);
        exp_q.push_back('{4'h0, 8'h0, 8'h0, 8'h2, 1'b1, 2'h3});
        soft_req <= 4'h1;
        @(posedge clock);
        soft_req <= 4'h0;
        wait_done("memory_move");
        check("holding", 16'(holding),
            16'((base_addr[7:0] + 8'h01) ^ 8'h5a));
        check("mask_src", 16'(mask[0]), 16'h0);
        check("mask_dst", 16'(mask[1]), 16'h1);
        check("tc_dst", 16'(tc_status[1]), 16'h1);
        summarize();
    end

    // Cut a hang short; the run needs well under 20000 cycles
    initial begin
        #(8 * 40000);
        bad_count++;
        summarize();
    end
endmodule
